// ===== include/urbf_pkg.sv
package urbf_pkg;

	// ****************************************
	// widths and depths
	// ****************************************
	localparam int unsigned URBF_DATA_W     = 8;
	localparam int unsigned URBF_ENTRY_W    = 11;
	localparam int unsigned URBF_ERR_LSB    = 8;
	localparam int unsigned URBF_FIFO_DEPTH = 4;
	localparam int unsigned URBF_ADDR_W     = 8;
	localparam int unsigned URBF_DIV_W      = 16;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] URBF_OFF_DATA   = 8'h00;
	localparam logic [7:0] URBF_OFF_STATUS = 8'h04;
	localparam logic [7:0] URBF_OFF_CTRL   = 8'h08;
	localparam logic [7:0] URBF_OFF_DIV    = 8'h0c;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned URBF_ST_NEMPTY = 0;
	localparam int unsigned URBF_ST_OVR    = 1;
	localparam int unsigned URBF_ST_BB     = 3;
	localparam int unsigned URBF_ST_BE     = 4;
	localparam int unsigned URBF_ST_EIF    = 5;
	localparam int unsigned URBF_ST_LOCK   = 6;
	localparam int unsigned URBF_CT_EN     = 0;
	localparam int unsigned URBF_CT_PAR    = 1;
	localparam int unsigned URBF_CT_ODD    = 2;
	localparam int unsigned URBF_EB_PAR    = 8;
	localparam int unsigned URBF_EB_FRM    = 9;
	localparam int unsigned URBF_EB_OVR    = 10;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [2:0]  URBF_CTRL_RST = 3'h0;
	localparam logic [15:0] URBF_DIV_RST  = 16'h043d;

	// ****************************************
	// receiver states
	// ****************************************
	typedef enum logic [1:0] {
		URBF_RX_IDLE  = 2'b01,
		URBF_RX_SHIFT = 2'b10
	} urbf_rx_st_t;

endpackage

// ===== rtl/urbf_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module urbf_fifo
	import urbf_pkg::*;
#(
	parameter int unsigned WIDTH   = URBF_ENTRY_W,
	parameter int unsigned DEPTH   = URBF_FIFO_DEPTH,
	parameter int unsigned ERR_LSB = URBF_ERR_LSB
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  err_any
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH-1:0] vld_reg;
	logic [DEPTH-1:0] vld_next;
	logic [DEPTH-1:0] slot_err;
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign in_ready  = ~vld_reg[wr_ptr_reg];
	assign out_valid = vld_reg[rd_ptr_reg];
	assign out_data  = mem[rd_ptr_reg];
	assign err_any   = |(vld_reg & slot_err);

	// ****************************************
	// per-slot error summary
	// ****************************************
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		assign slot_err[i] = |mem[i][WIDTH-1:ERR_LSB];
		assign vld_next[i] = (push && wr_ptr_reg == AW'(i)) |
			(vld_reg[i] & ~(pop && rd_ptr_reg == AW'(i)));
	end

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vld_reg    <= '0;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			vld_reg    <= vld_next;
			wr_ptr_reg <= push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
			rd_ptr_reg <= pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/urbf_rx_char.sv
`timescale 1ns/10ps
`default_nettype none
module urbf_rx_char
	import urbf_pkg::*;
#(
	parameter int unsigned DIV_W = URBF_DIV_W
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             en,
	input  wire logic             rxd,
	input  wire logic             par_en,
	input  wire logic             odd,
	input  wire logic [DIV_W-1:0] div,
	output logic                  done,
	output logic [7:0]            data,
	output logic                  par_err,
	output logic                  frm_err,
	output logic                  brk
);
	urbf_rx_st_t      st_reg;
	urbf_rx_st_t      st_next;
	logic [DIV_W-1:0] cnt_reg;
	logic [3:0]       nbit_reg;
	logic [10:0]      sh_reg;
	wire              tick     = (cnt_reg == '0);
	wire  [3:0]       last_bit = par_en ? 4'ha : 4'h9;
	wire              false_st = tick && nbit_reg == 4'h0 && rxd;
	wire              fin      = tick && nbit_reg == last_bit;
	wire              par_bit  = sh_reg[9];
	wire              stop_bit = sh_reg[10];

	// ****************************************
	// frame fields, valid from done onward
	// ****************************************
	assign data    = par_en ? sh_reg[8:1] : sh_reg[9:2];
	assign frm_err = ~stop_bit;
	assign par_err = par_en & (^{data, par_bit} ^ odd);
	assign brk     = (data == 8'h00) & ~stop_bit & ~(par_en & par_bit);

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			URBF_RX_IDLE:  if (en && !rxd) st_next = URBF_RX_SHIFT;
			URBF_RX_SHIFT: if (false_st || fin) st_next = URBF_RX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg   <= URBF_RX_IDLE;
			cnt_reg  <= '0;
			nbit_reg <= '0;
			sh_reg   <= '0;
			done     <= 1'b0;
		end else begin
			st_reg <= st_next;
			done   <= (st_reg == URBF_RX_SHIFT) && fin;
			if (st_reg == URBF_RX_IDLE) begin
				cnt_reg  <= div >> 1;
				nbit_reg <= '0;
			end else if (tick) begin
				cnt_reg  <= div - 1'b1;
				nbit_reg <= nbit_reg + 4'h1;
				sh_reg   <= {rxd, sh_reg[10:1]};
			end else begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/urbf_top.sv
// Notes on behaviour
// - null char with zero parity/stop sets break-begin
// - after break-begin, further null framing chars dropped
// - break-end only sets while break interlock held
// - interlock plus receive-pin rising edge sets break-end
// - break-end re-arms break-begin, lets null framing chars into fifo again
// - fifo-error flag is read-only to software
// - no entry errors: flag clear, dma allowed
// - any entry error: flag set, irq, dma blocked
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module urbf_top
	import urbf_pkg::*;
#(
	parameter int unsigned ADDR_W = URBF_ADDR_W,
	parameter int unsigned DIV_W  = URBF_DIV_W,
	parameter int unsigned DEPTH  = URBF_FIFO_DEPTH
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rxd,
	input  wire logic              dma_ack,
	output logic                   rx_dma_req,
	output logic                   irq_req
);

	// ****************************************
	// state
	// ****************************************
	logic [2:0]              ctrl_reg;
	logic [2:0]              ctrl_next;
	logic [DIV_W-1:0]        div_reg;
	logic [DIV_W-1:0]        div_next;
	logic                    bb_reg;
	logic                    bb_next;
	logic                    be_reg;
	logic                    be_next;
	logic                    lock_reg;
	logic                    lock_next;
	logic                    eif_reg;
	logic                    ovr_reg;
	logic                    ovr_next;
	logic                    rxd_q_reg;
	logic [31:0]             prdata_next;
	logic                    pslverr_next;

	// ****************************************
	// receiver and fifo wiring
	// ****************************************
	logic                    rx_done;
	logic [7:0]              rx_data;
	logic                    rx_par_err;
	logic                    rx_frm_err;
	logic                    rx_brk;
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	logic [URBF_ENTRY_W-1:0] fifo_out_data;
	logic                    fifo_err_any;
	logic [URBF_ENTRY_W-1:0] entry;

	wire rx_en   = ctrl_reg[URBF_CT_EN];
	wire par_en  = ctrl_reg[URBF_CT_PAR];
	wire par_odd = ctrl_reg[URBF_CT_ODD];

	urbf_rx_char #(
		.DIV_W   (DIV_W)
	) u_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (rx_en),
		.rxd     (rxd),
		.par_en  (par_en),
		.odd     (par_odd),
		.div     (div_reg),
		.done    (rx_done),
		.data    (rx_data),
		.par_err (rx_par_err),
		.frm_err (rx_frm_err),
		.brk     (rx_brk)
	);

	// ****************************************
	// break detection
	// ****************************************
	wire brk_char = rx_done & rx_brk & rx_frm_err;
	wire bb_set   = brk_char & ~lock_reg;
	wire rxd_rise = rxd & ~rxd_q_reg;
	wire be_set   = lock_reg & rxd_rise;

	// one null framing char per break, rest dropped
	wire drop_brk = brk_char & lock_reg;
	wire keep     = rx_done & ~drop_brk;
	wire stored   = keep & fifo_in_ready;
	wire overrun  = keep & ~fifo_in_ready;

	assign entry = {ovr_reg, rx_frm_err, rx_par_err, rx_data};

	// ****************************************
	// apb decode
	// ****************************************
	wire setup     = psel & ~penable;
	wire access    = psel & penable & pready;
	wire sel_data  = (paddr == ADDR_W'(URBF_OFF_DATA));
	wire sel_stat  = (paddr == ADDR_W'(URBF_OFF_STATUS));
	wire sel_ctrl  = (paddr == ADDR_W'(URBF_OFF_CTRL));
	wire sel_div   = (paddr == ADDR_W'(URBF_OFF_DIV));
	wire hit       = sel_data | sel_stat | sel_ctrl | sel_div;
	wire wr_done   = access & pwrite & ~pslverr;
	wire wr_stat   = wr_done & sel_stat;
	wire wr_ctrl   = wr_done & sel_ctrl;
	wire wr_div    = wr_done & sel_div;
	wire rd_pop    = access & ~pwrite & sel_data & ~pslverr;
	wire clr_bb    = wr_stat & pwdata[URBF_ST_BB];
	wire clr_be    = wr_stat & pwdata[URBF_ST_BE];
	wire fifo_pop  = rd_pop | dma_ack;

	wire [31:0] rd_data = {{(32 - URBF_ENTRY_W){1'b0}}, fifo_out_data};
	wire [31:0] rd_stat = {25'h0, lock_reg, eif_reg, be_reg, bb_reg,
		1'b0, ovr_reg, fifo_out_valid};
	wire [31:0] rd_ctrl = {29'h0, ctrl_reg};
	wire [31:0] rd_div  = {{(32 - DIV_W){1'b0}}, div_reg};

	wire [31:0] rd_mux =
		sel_data ? rd_data :
		sel_stat ? rd_stat :
		sel_ctrl ? rd_ctrl :
		sel_div  ? rd_div  : 32'h0;

	// ****************************************
	// next-state terms
	// ****************************************
	// set wins over a same-cycle software clear
	assign bb_next   = bb_set | (bb_reg & ~clr_bb);
	assign be_next   = be_set | (be_reg & ~clr_be);
	assign lock_next = bb_set | (lock_reg & ~be_set);
	assign ovr_next  = overrun | (ovr_reg & ~stored);
	assign ctrl_next = wr_ctrl ? pwdata[2:0] : ctrl_reg;
	assign div_next  = wr_div ? pwdata[DIV_W-1:0] : div_reg;
	assign prdata_next  = setup ? (pwrite ? 32'h0 : rd_mux) : prdata;
	assign pslverr_next = setup ? ~hit : pslverr;

	// ****************************************
	// receive fifo
	// ****************************************
	urbf_fifo #(
		.WIDTH     (URBF_ENTRY_W),
		.DEPTH     (DEPTH),
		.ERR_LSB   (URBF_ERR_LSB)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (keep),
		.in_ready  (fifo_in_ready),
		.in_data   (entry),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data),
		.err_any   (fifo_err_any)
	);

	// ****************************************
	// apb slave
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setup;
			pslverr <= pslverr_next;
			prdata  <= prdata_next;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= URBF_CTRL_RST;
			div_reg  <= URBF_DIV_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			div_reg  <= div_next;
		end
	end

	// ****************************************
	// break flags and interlock
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bb_reg    <= 1'b0;
			be_reg    <= 1'b0;
			lock_reg  <= 1'b0;
			ovr_reg   <= 1'b0;
			rxd_q_reg <= 1'b1;
		end else begin
			bb_reg    <= bb_next;
			be_reg    <= be_next;
			lock_reg  <= lock_next;
			ovr_reg   <= ovr_next;
			rxd_q_reg <= rxd;
		end
	end

	// ****************************************
	// fifo error flag, dma and interrupt
	// ****************************************
	// error flag follows entry error bits only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eif_reg    <= 1'b0;
			rx_dma_req <= 1'b0;
			irq_req    <= 1'b0;
		end else begin
			eif_reg    <= fifo_err_any;
			rx_dma_req <= fifo_out_valid & ~fifo_pop & ~fifo_err_any;
			irq_req    <= bb_next | be_next | fifo_err_any;
		end
	end

endmodule
`default_nettype wire

// ===== tb/urbf_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module urbf_assertions
	import urbf_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              rxd,
	input wire logic              dma_ack,
	input wire logic              rx_dma_req,
	input wire logic              irq_req
);
	// ****************************************
	// apb and status flag checks
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence st_rd;
		psel && penable && pready && !pwrite && paddr == URBF_OFF_STATUS;
	endsequence
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside setup");
	unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h0c |-> pslverr)
		else $error("unmapped access without error");
	err_irq_a: assert property (st_rd ##0 prdata[URBF_ST_EIF] |-> $past(irq_req))
		else $error("fifo error without irq");
	err_dma_a: assert property (st_rd ##0 prdata[URBF_ST_EIF] |-> !$past(rx_dma_req))
		else $error("dma request despite fifo error");
	flag_irq_a: assert property (st_rd ##0 (prdata[3] || prdata[4]) |-> $past(irq_req))
		else $error("break flag without irq");
	lock_free_a: assert property (st_rd ##0 prdata[URBF_ST_BE] |-> !prdata[URBF_ST_LOCK])
		else $error("break end left interlock set");
endmodule
bind urbf_top urbf_assertions #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .dma_ack(dma_ack),
	.rx_dma_req(rx_dma_req), .irq_req(irq_req));
`default_nettype wire

// ===== tb/urbf_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module urbf_tx_model
	import urbf_pkg::*;
#(
	parameter int BIT_CLKS = 16
) (
	input wire logic pclk,
	output logic     rxd
);
	// ****************************************
	// start, 8 data lsb first, stop
	// ****************************************
	initial rxd = 1'b1;
	task automatic send(input logic [7:0] d, input logic stp, input logic keep_low);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CLKS) @(posedge pclk);
		end
		if (!keep_low) begin
			rxd <= 1'b1;
			@(posedge pclk);
		end
	endtask
	// start, 8 data lsb first, parity, stop, one idle clock
	task automatic send_par(input logic [7:0] d, input logic par, input logic stp);
		logic [10:0] f;
		f = {stp, par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BIT_CLKS) @(posedge pclk);
		end
		rxd <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic release_line();
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import urbf_pkg::*;
;
	typedef struct packed {
		logic [7:0]  d;
		logic        stp;
		logic [31:0] ent;
		logic        dma;
	} urbf_row_t;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        dma_ack = 1'b0;
	logic        se;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         rx_dma_req;
	wire         irq_req;
	wire         rxd;
	int          num_errors = 0;
	int          num_checks = 0;
	urbf_row_t   rows[4] = '{'{8'h55, 1'b1, 32'h055, 1'b1}, '{8'ha3, 1'b1, 32'h0a3, 1'b1},
		'{8'h00, 1'b1, 32'h000, 1'b1}, '{8'h7e, 1'b0, 32'h27e, 1'b0}};

	always #4 pclk = ~pclk;

	urbf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .dma_ack(dma_ack), .rx_dma_req(rx_dma_req),
		.irq_req(irq_req));
	urbf_tx_model #(.BIT_CLKS(16)) i_tx (.pclk(pclk), .rxd(rxd));

	// ****************************************
	// helpers
	// ****************************************
	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd & m, e);
	endtask
	task automatic gap(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		gap(5);
		presetn <= 1'b1;
		gap(1);
		rdc("div_rst", URBF_OFF_DIV, 32'hffff, 32'h043d);
		rdc("ctrl_rst", URBF_OFF_CTRL, 32'h7, 32'h0);
		rdc("unmapped", 8'h20, 32'hffffffff, 32'h0);
		chk("slverr", {31'h0, se}, 32'h1);
		apb(1'b1, URBF_OFF_DIV, 32'h10);
		apb(1'b1, URBF_OFF_CTRL, 32'h1);
		foreach (rows[i]) begin
			i_tx.send(rows[i].d, rows[i].stp, 1'b0);
			gap(4);
			chk("dma", {31'h0, rx_dma_req}, {31'h0, rows[i].dma});
			chk("irq", {31'h0, irq_req}, {31'h0, !rows[i].dma});
			rdc("eif", URBF_OFF_STATUS, 32'h20, {26'h0, !rows[i].dma, 5'h0});
			rdc("data", URBF_OFF_DATA, 32'h7ff, rows[i].ent);
		end
		for (int i = 0; i < 5; i++) i_tx.send(8'(16 + i), i != 3, 1'b0);
		gap(4);
		chk("dma_blk", {31'h0, rx_dma_req}, 32'h0);
		apb(1'b1, URBF_OFF_STATUS, 32'h20);
		rdc("eif_ro", URBF_OFF_STATUS, 32'h21, 32'h21);
		for (int i = 0; i < 4; i++) rdc("fifo", URBF_OFF_DATA, 32'h7ff, i == 3 ? 32'h213 : 16 + i);
		rdc("drained", URBF_OFF_STATUS, 32'h21, 32'h0);
		i_tx.send(8'h00, 1'b0, 1'b1);
		gap(192);
		rdc("brk_begin", URBF_OFF_STATUS, 32'h79, 32'h69);
		chk("brk_irq", {31'h0, irq_req}, 32'h1);
		rdc("brk_entry", URBF_OFF_DATA, 32'h7ff, 32'h600);
		rdc("brk_drop", URBF_OFF_STATUS, 32'h79, 32'h48);
		i_tx.release_line();
		gap(8);
		rdc("brk_end", URBF_OFF_STATUS, 32'h58, 32'h18);
		apb(1'b1, URBF_OFF_STATUS, 32'h18);
		rdc("brk_clr", URBF_OFF_STATUS, 32'h18, 32'h0);
		gap(192);
		dma_ack <= 1'b1;
		gap(1);
		dma_ack <= 1'b0;
		gap(1);
		rdc("dma_pop", URBF_OFF_STATUS, 32'h1, 32'h0);
		i_tx.send(8'h5a, 1'b1, 1'b0);
		gap(4);
		rdc("after_brk", URBF_OFF_DATA, 32'h3ff, 32'h05a);
		apb(1'b1, URBF_OFF_CTRL, 32'h3);
		i_tx.send_par(8'h5a, 1'b1, 1'b1);
		gap(4);
		chk("par_dma", {31'h0, rx_dma_req}, 32'h0);
		rdc("par_even", URBF_OFF_DATA, 32'h3ff, 32'h15a);
		apb(1'b1, URBF_OFF_CTRL, 32'h7);
		i_tx.send_par(8'h5a, 1'b1, 1'b1);
		gap(4);
		rdc("par_odd", URBF_OFF_DATA, 32'h3ff, 32'h05a);
		tally_and_finish();
	end
endmodule
`default_nettype wire
